// >>> fifo_flag_cfg_params.svh
// Register offsets, field positions, reset values and masks of the flag/polarity block
`ifndef FIFO_FLAG_CFG_PARAMS_SVH
`define FIFO_FLAG_CFG_PARAMS_SVH

`define REG_IF_CFG        6'h01
`define REG_ROUTE_AB      6'h02
`define REG_ROUTE_CD      6'h03
`define REG_SENSE_CTL     6'h04
`define REG_PTR_LO        6'h3A
`define REG_PTR_HI        6'h3B
`define REG_IND_DATA      6'h3C
`define ADDR_SENSE_ALT    16'hE609

`define IF_CFG_RESET      8'hC9
`define ROUTE_RESET       8'h00
`define SENSE_RESET       8'h00
`define PTR_RESET         8'h00

`define POL_WAKE          7
`define POL_PACKET_END_STROBE        5
`define POL_OE            4
`define POL_RD            3
`define POL_WR            2
`define POL_EF            1
`define POL_FF            0

`define SENSE_CTL_WMASK   8'hA3
`define SENSE_ALT_WMASK   8'hBF
`define SENSE_STROBE_MASK 8'h1C

`endif

// >>> fifo_flag_cfg_pkg.sv
// Types shared by the flag routing and polarity block
package fifo_flag_cfg_pkg;

   typedef struct packed {
      logic [3:0] pf;
      logic [3:0] ef;
      logic [3:0] ff;
   } ep_flags_t;

   typedef struct packed {
      logic clk_src;
      logic clk_48;
      logic clk_oe;
      logic clk_pol;
      logic strobe_mode_select;
      logic standby;
      logic fourth_pin_mode;
      logic pullup_detach;
   } interface_config_t;

   typedef enum logic [2:0] {
      ASM_IDLE = 3'b001,
      ASM_HI   = 3'b010,
      ASM_LO   = 3'b100
   } nib_state_t;

   typedef enum logic [1:0] {
      KIND_NONE = 2'h0,
      KIND_PF   = 2'h1,
      KIND_EF   = 2'h2,
      KIND_FF   = 2'h3
   } flag_kind_t;

endpackage

// >>> fifo_flag_and_polarity_config.sv
// Interface configuration, flag routing and pin polarity register bank
// Notes on behaviour
// - Asynchronous mode (reset) treats read/write controls as direct strobes, no clock.
// - Synchronous mode samples read/write as enables on interface clock ticks.
// - Writing standby bit one stops the oscillator, entering low power.
// - Standby ends on bus activity or wake pin at configured polarity.
// - Fourth pin is chip-select input when mode bit zero, flag output when one.
// - Detach bit one floats the D+ pull-up; zero pulls it high.
// - Each flag output has a 4-bit code; A,B in first, C,D second register.
// - Code zero gives fixed flags on the FIFO chosen by select pins.
// - Nonzero codes pick flag kind and endpoint regardless of select pins.
// - Polarity bit 7 makes wake pin active low at zero, high at one.
// - Polarity bit 5 makes packet-end input active low at zero, high at one.
// - Routed empty flag drives low when empty if bit 1 zero, else high.
// - Routed full flag drives low when full if bit 0 zero, else high.
// - Strobe polarity bits of primary register are read-only, active low at reset.
// - Alternate register, indirect only, same layout, strobe polarity bits writable.
// - Indirect access: low pointer at 0x3A, high at 0x3B, data at 0x3C.
// - Each byte arrives as two nibble writes, upper first; device joins them.
`timescale 1ns/1ns
`default_nettype none
`include "fifo_flag_cfg_params.svh"

module fifo_flag_and_polarity_config (
   input  wire logic                          i_clk,
   input  wire logic                          i_arst_n,
   input  wire logic                          i_cmd_addr_wr,
   input  wire logic [5:0]                    i_cmd_addr,
   input  wire logic                          i_cmd_data_wr,
   input  wire logic [3:0]                    i_cmd_nibble,
   input  wire logic                          i_cmd_rd,
   input  wire logic                          i_interface_clock_pin,
   input  wire logic                          i_fifo_read_strobe,
   input  wire logic                          i_fifo_write_strobe,
   input  wire logic                          i_fifo_output_enable,
   input  wire logic                          i_packet_end_strobe,
   input  wire logic                          i_wake_pin,
   input  wire logic                          i_bus_activity,
   input  wire logic [2:0]                    i_fifo_select_pins,
   input  wire fifo_flag_cfg_pkg::ep_flags_t  i_ep_flags,
   input  wire logic                          i_flag_d_pin,
   output logic [7:0]                         o_rd_data,
   output logic                               o_rd_valid,
   output logic                               o_fifo_read_evt,
   output logic                               o_fifo_write_evt,
   output logic                               o_fifo_oe_active,
   output logic                               o_packet_end_evt,
   output logic                               o_osc_stop,
   output logic                               o_pullup_en,
   output logic                               o_chip_select,
   output logic                               o_flag_out_a,
   output logic                               o_flag_out_b,
   output logic                               o_flag_out_c,
   output logic                               o_flag_out_d,
   output logic                               o_flag_out_d_oe
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers and decode

   fifo_flag_cfg_pkg::interface_config_t cfg_q;
   fifo_flag_cfg_pkg::nib_state_t        nib_q;
   logic [5:0]  cmd_addr_q;
   logic [3:0]  hi_nib_q;
   logic [7:0]  route_ab_q;
   logic [7:0]  route_cd_q;
   logic [7:0]  sense_q;
   logic [7:0]  ptr_lo_q;
   logic [7:0]  ptr_hi_q;
   logic [7:0]  rd_data_q;
   logic        rd_valid_q;
   logic        commit;
   logic [7:0]  wbyte;
   logic        alt_hit;
   logic [7:0]  rd_mux;
   logic        wake_req;

   assign commit  = (nib_q == fifo_flag_cfg_pkg::ASM_LO) && i_cmd_data_wr
                    && !i_cmd_addr_wr;
   assign wbyte   = {hi_nib_q, i_cmd_nibble};
   assign alt_hit = ({ptr_hi_q, ptr_lo_q} == `ADDR_SENSE_ALT);

   ////////////////////////////////////////////////////////////////////////////
   // Nibble assembly of command data

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cmd_addr_q <= 6'h00;
      end else if (i_cmd_addr_wr) begin
         cmd_addr_q <= i_cmd_addr;
      end
   end

   // A new command address restarts the pair, so a stray nibble cannot skew
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         nib_q    <= fifo_flag_cfg_pkg::ASM_IDLE;
         hi_nib_q <= 4'h0;
      end else if (i_cmd_addr_wr) begin
         nib_q <= fifo_flag_cfg_pkg::ASM_HI;
      end else if (i_cmd_data_wr) begin
         unique case (nib_q)
            fifo_flag_cfg_pkg::ASM_HI: begin
               hi_nib_q <= i_cmd_nibble;
               nib_q    <= fifo_flag_cfg_pkg::ASM_LO;
            end
            fifo_flag_cfg_pkg::ASM_LO: begin
               nib_q <= fifo_flag_cfg_pkg::ASM_IDLE;
            end
            fifo_flag_cfg_pkg::ASM_IDLE: begin
               nib_q <= fifo_flag_cfg_pkg::ASM_IDLE;
            end
            default: begin
               nib_q <= fifo_flag_cfg_pkg::ASM_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register writes

   // A write of the standby bit wins over a wake in the same cycle
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cfg_q <= `IF_CFG_RESET;
      end else if (commit && cmd_addr_q == `REG_IF_CFG) begin
         cfg_q <= wbyte;
      end else if (cfg_q.standby && wake_req) begin
         cfg_q.standby <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         route_ab_q <= `ROUTE_RESET;
         route_cd_q <= `ROUTE_RESET;
      end else if (commit && cmd_addr_q == `REG_ROUTE_AB) begin
         route_ab_q <= wbyte;
      end else if (commit && cmd_addr_q == `REG_ROUTE_CD) begin
         route_cd_q <= wbyte;
      end
   end

   // One polarity store; the primary view cannot touch the strobe bits
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sense_q <= `SENSE_RESET;
      end else if (commit && cmd_addr_q == `REG_SENSE_CTL) begin
         sense_q <= (sense_q & ~`SENSE_CTL_WMASK)
                    | (wbyte & `SENSE_CTL_WMASK);
      end else if (commit && cmd_addr_q == `REG_IND_DATA && alt_hit) begin
         sense_q <= (sense_q & ~`SENSE_ALT_WMASK)
                    | (wbyte & `SENSE_ALT_WMASK);
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ptr_lo_q <= `PTR_RESET;
         ptr_hi_q <= `PTR_RESET;
      end else if (commit && cmd_addr_q == `REG_PTR_LO) begin
         ptr_lo_q <= wbyte;
      end else if (commit && cmd_addr_q == `REG_PTR_HI) begin
         ptr_hi_q <= wbyte;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register reads

   always_comb begin
      unique case (cmd_addr_q)
         `REG_IF_CFG:    rd_mux = cfg_q;
         `REG_ROUTE_AB:  rd_mux = route_ab_q;
         `REG_ROUTE_CD:  rd_mux = route_cd_q;
         `REG_SENSE_CTL: rd_mux = sense_q;
         `REG_PTR_LO:    rd_mux = ptr_lo_q;
         `REG_PTR_HI:    rd_mux = ptr_hi_q;
         `REG_IND_DATA:  rd_mux = alt_hit ? sense_q : 8'h00;
         default:        rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rd_data_q  <= 8'h00;
         rd_valid_q <= 1'b0;
      end else begin
         rd_valid_q <= i_cmd_rd;
         if (i_cmd_rd) begin
            rd_data_q <= rd_mux;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Strobes, packet end and standby wake

   logic rd_act;
   logic wr_act;
   logic pe_act;
   logic interface_clock_pin_pin_q;
   logic interface_clock_pin_tick;
   logic rd_prev_q;
   logic wr_prev_q;
   logic pe_prev_q;
   logic rd_evt_q;
   logic wr_evt_q;
   logic oe_q;
   logic pe_evt_q;

   assign rd_act   = i_fifo_read_strobe ~^ sense_q[`POL_RD];
   assign wr_act   = i_fifo_write_strobe ~^ sense_q[`POL_WR];
   assign pe_act   = i_packet_end_strobe ~^ sense_q[`POL_PACKET_END_STROBE];
   assign wake_req = i_bus_activity
                     || (i_wake_pin ~^ sense_q[`POL_WAKE]);
   // The internal interface clock outruns this clock, so it ticks every cycle
   assign interface_clock_pin_tick = cfg_q.clk_src
                       || ((i_interface_clock_pin ^ cfg_q.clk_pol)
                           && !(interface_clock_pin_pin_q ^ cfg_q.clk_pol));

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         interface_clock_pin_pin_q <= 1'b0;
         rd_prev_q   <= 1'b0;
         wr_prev_q   <= 1'b0;
         pe_prev_q   <= 1'b0;
      end else begin
         interface_clock_pin_pin_q <= i_interface_clock_pin;
         rd_prev_q   <= rd_act;
         wr_prev_q   <= wr_act;
         pe_prev_q   <= pe_act;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rd_evt_q <= 1'b0;
         wr_evt_q <= 1'b0;
      end else if (cfg_q.strobe_mode_select) begin
         rd_evt_q <= rd_act && !rd_prev_q;
         wr_evt_q <= wr_act && !wr_prev_q;
      end else begin
         rd_evt_q <= rd_act && interface_clock_pin_tick;
         wr_evt_q <= wr_act && interface_clock_pin_tick;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         oe_q     <= 1'b0;
         pe_evt_q <= 1'b0;
      end else begin
         oe_q     <= i_fifo_output_enable ~^ sense_q[`POL_OE];
         pe_evt_q <= pe_act && !pe_prev_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Flag routing

   function automatic logic route_flag(
      input logic [3:0]                    code,
      input fifo_flag_cfg_pkg::flag_kind_t fixed_kind,
      input logic [1:0]                    sel,
      input fifo_flag_cfg_pkg::ep_flags_t  f,
      input logic [7:0]                    pol
   );
      fifo_flag_cfg_pkg::flag_kind_t kind;
      logic [1:0]                    ep;
      logic                          val;
      kind = fixed_kind;
      ep   = sel;
      if (code != 4'h0) begin
         kind = fifo_flag_cfg_pkg::flag_kind_t'(code[3:2]);
         ep   = code[1:0];
      end
      unique case (kind)
         fifo_flag_cfg_pkg::KIND_PF: val = f.pf[ep];
         fifo_flag_cfg_pkg::KIND_EF: val = f.ef[ep] ~^ pol[`POL_EF];
         fifo_flag_cfg_pkg::KIND_FF: val = f.ff[ep] ~^ pol[`POL_FF];
         fifo_flag_cfg_pkg::KIND_NONE: val = 1'b0;
      endcase
      return val;
   endfunction

   logic [3:0] flag_q;
   logic       cs_q;
   logic       pullup_q;

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         flag_q <= 4'h0;
      end else begin
         flag_q[0] <= route_flag(route_ab_q[3:0], fifo_flag_cfg_pkg::KIND_PF,
                                 i_fifo_select_pins[1:0], i_ep_flags, sense_q);
         flag_q[1] <= route_flag(route_ab_q[7:4], fifo_flag_cfg_pkg::KIND_FF,
                                 i_fifo_select_pins[1:0], i_ep_flags, sense_q);
         flag_q[2] <= route_flag(route_cd_q[3:0], fifo_flag_cfg_pkg::KIND_EF,
                                 i_fifo_select_pins[1:0], i_ep_flags, sense_q);
         flag_q[3] <= route_flag(route_cd_q[7:4], fifo_flag_cfg_pkg::KIND_PF,
                                 i_fifo_select_pins[1:0], i_ep_flags, sense_q);
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cs_q     <= 1'b0;
         pullup_q <= 1'b0;
      end else begin
         cs_q     <= !cfg_q.fourth_pin_mode && !i_flag_d_pin;
         pullup_q <= !cfg_q.pullup_detach;
      end
   end

   assign o_rd_data        = rd_data_q;
   assign o_rd_valid       = rd_valid_q;
   assign o_fifo_read_evt  = rd_evt_q;
   assign o_fifo_write_evt = wr_evt_q;
   assign o_fifo_oe_active = oe_q;
   assign o_packet_end_evt = pe_evt_q;
   assign o_osc_stop       = cfg_q.standby;
   assign o_pullup_en      = pullup_q;
   assign o_chip_select    = cs_q;
   assign o_flag_out_a     = flag_q[0];
   assign o_flag_out_b     = flag_q[1];
   assign o_flag_out_c     = flag_q[2];
   assign o_flag_out_d     = flag_q[3];
   assign o_flag_out_d_oe  = cfg_q.fourth_pin_mode;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);

   sequence s_alt_write;
      commit && cmd_addr_q == `REG_IND_DATA && alt_hit;
   endsequence

   sequence s_nibble_pair;
      (i_cmd_data_wr && nib_q == fifo_flag_cfg_pkg::ASM_HI && !i_cmd_addr_wr)
      ##1 (i_cmd_data_wr && !i_cmd_addr_wr);
   endsequence

   a_strobe_mode_select_strobe: assert property (
      cfg_q.strobe_mode_select && rd_act && !rd_prev_q |=> o_fifo_read_evt)
      else $error("strobe_mode_select read strobe edge not reported");
   a_sync_enable: assert property (
      !cfg_q.strobe_mode_select && wr_act && interface_clock_pin_tick |=> o_fifo_write_evt)
      else $error("sync write enable not reported");
   a_standby_enter: assert property (
      commit && cmd_addr_q == `REG_IF_CFG && wbyte[2] |=> o_osc_stop)
      else $error("standby write did not stop oscillator");
   a_wake_exit: assert property (
      o_osc_stop && i_bus_activity && !commit |=> !o_osc_stop)
      else $error("bus activity did not end standby");
   a_fourth_pin: assert property (
      o_flag_out_d_oe |=> !o_chip_select)
      else $error("chip select active in flag mode");
   a_chip_select: assert property (
      !cfg_q.fourth_pin_mode && !i_flag_d_pin |=> o_chip_select)
      else $error("chip select not taken from fourth pin");
   a_pullup_drive: assert property (
      $fell(cfg_q.pullup_detach) |=> o_pullup_en)
      else $error("pull-up not driven after attach");
   a_empty_sense: assert property (
      route_cd_q[3:0] == 4'h8 && i_ep_flags.ef[0] |=>
      o_flag_out_c == $past(sense_q[`POL_EF]))
      else $error("empty flag polarity wrong");
   a_full_sense: assert property (
      route_ab_q[7:4] == 4'hF && i_ep_flags.ff[3] |=>
      o_flag_out_b == $past(sense_q[`POL_FF]))
      else $error("full flag polarity wrong");
   a_strobe_ro: assert property (
      commit && cmd_addr_q == `REG_SENSE_CTL |=>
      $stable(sense_q[4:2]))
      else $error("primary write changed strobe polarity");
   a_alt_write: assert property (
      s_alt_write |=> sense_q[4:2] == $past(wbyte[4:2]))
      else $error("alternate write did not set strobe polarity");
   a_nibble_join: assert property (
      s_nibble_pair |=> $past(hi_nib_q) == $past(i_cmd_nibble, 2))
      else $error("upper nibble not kept first");
   a_reserved_low: assert property (
      route_ab_q[3:2] == 2'h0 && route_ab_q[1:0] != 2'h0 |=> !o_flag_out_a)
      else $error("reserved code drove flag active");

endmodule

`default_nettype wire

// >>> fifo_host_master.sv
// Behavioural external master that drives the nibble-wide command port
`timescale 1ns/1ns
`default_nettype none
`include "fifo_flag_cfg_params.svh"
module fifo_host_master (
   input  wire logic       i_clk,
   input  wire logic [7:0] i_rd_data,
   input  wire logic       i_rd_valid,
   output logic            o_addr_wr,
   output logic [5:0]      o_addr,
   output logic            o_data_wr,
   output logic [3:0]      o_nibble,
   output logic            o_rd
);
   initial begin
      o_addr_wr = 1'b0;
      o_addr    = 6'h00;
      o_data_wr = 1'b0;
      o_nibble  = 4'h0;
      o_rd      = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////
   // Address, then upper and lower nibble on back-to-back cycles
   task automatic wr_reg(input logic [5:0] a, input logic [7:0] v);
      @(negedge i_clk);
      o_addr_wr = 1'b1;
      o_addr    = a;
      @(negedge i_clk);
      o_addr_wr = 1'b0;
      o_addr    = ~a;       // Released lines must not keep the last value
      o_data_wr = 1'b1;
      o_nibble  = v[7:4];
      @(negedge i_clk);
      o_nibble  = v[3:0];
      @(negedge i_clk);
      o_data_wr = 1'b0;
      o_nibble  = ~v[3:0];
   endtask
   task automatic rd_reg(input logic [5:0] a, output logic [7:0] v,
                         output logic ok);
      @(negedge i_clk);
      o_addr_wr = 1'b1;
      o_addr    = a;
      @(negedge i_clk);
      o_addr_wr = 1'b0;
      o_addr    = ~a;
      o_rd      = 1'b1;
      @(negedge i_clk);
      o_rd      = 1'b0;
      ok        = (i_rd_valid === 1'b1);
      v         = i_rd_data;
   endtask
   task automatic ind_wr(input logic [15:0] ptr, input logic [7:0] v);
      wr_reg(`REG_PTR_LO, ptr[7:0]);
      wr_reg(`REG_PTR_HI, ptr[15:8]);
      wr_reg(`REG_IND_DATA, v);
   endtask
   // Read the primary copy so untouched bits survive the indirect write
   task automatic alt_rmw(input logic [7:0] set_m, output logic ok);
      logic [7:0] v;
      rd_reg(`REG_SENSE_CTL, v, ok);
      ind_wr(`ADDR_SENSE_ALT, v | set_m);
   endtask
endmodule
`default_nettype wire

// >>> fifo_flag_and_polarity_config_tb_top.sv
// Self-checking bench for the flag routing and polarity register bank
`timescale 1ns/1ns
`default_nettype none
`include "fifo_flag_cfg_params.svh"
module fifo_flag_and_polarity_config_tb_top;
   logic       clk, arst_n, interface_clock_pin, rd_s, wr_s, oe_s, pe_s, wake, bus_act;
   logic       fd_pin, a_wr, d_wr, c_rd, rd_v;
   logic       rd_e, wr_e, oe_a, pe_e, osc, pu, cs, fa, fb, fc, fd, fd_oe;
   logic [5:0] c_addr;
   logic [3:0] nib;
   logic [2:0] sel;
   logic [7:0] rd_d;
   int         bad_count, n_tests, rdc, wrc, pec;
   fifo_flag_cfg_pkg::ep_flags_t flags;

   fifo_flag_and_polarity_config dut_u (.i_clk(clk), .i_arst_n(arst_n),
      .i_cmd_addr_wr(a_wr), .i_cmd_addr(c_addr), .i_cmd_data_wr(d_wr),
      .i_cmd_nibble(nib), .i_cmd_rd(c_rd), .i_interface_clock_pin(interface_clock_pin),
      .i_fifo_read_strobe(rd_s), .i_fifo_write_strobe(wr_s),
      .i_fifo_output_enable(oe_s), .i_packet_end_strobe(pe_s),
      .i_wake_pin(wake), .i_bus_activity(bus_act), .i_fifo_select_pins(sel),
      .i_ep_flags(flags), .i_flag_d_pin(fd_pin), .o_rd_data(rd_d),
      .o_rd_valid(rd_v), .o_fifo_read_evt(rd_e), .o_fifo_write_evt(wr_e),
      .o_fifo_oe_active(oe_a), .o_packet_end_evt(pe_e), .o_osc_stop(osc),
      .o_pullup_en(pu), .o_chip_select(cs), .o_flag_out_a(fa),
      .o_flag_out_b(fb), .o_flag_out_c(fc), .o_flag_out_d(fd),
      .o_flag_out_d_oe(fd_oe));
   fifo_host_master m_u (.i_clk(clk), .i_rd_data(rd_d), .i_rd_valid(rd_v),
      .o_addr_wr(a_wr), .o_addr(c_addr), .o_data_wr(d_wr), .o_nibble(nib),
      .o_rd(c_rd));

   always #25 clk = ~clk;
   always @(posedge clk) begin
      rdc += int'(rd_e === 1'b1);
      wrc += int'(wr_e === 1'b1);
      pec += int'(pe_e === 1'b1);
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e, string s);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR t=%0t %s got %h exp %h", $time, s, g, e);
      end
   endtask
   task automatic rchk(input logic [5:0] a, input logic [7:0] e);
      logic [7:0] v;
      logic       ok;
      m_u.rd_reg(a, v, ok);
      chk({7'h00, ok}, 8'h01, "read valid");
      chk(v, e, "read data");
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] v);
      m_u.wr_reg(a, v);
      repeat (2) @(negedge clk);
   endtask
   task automatic bit_chk(input logic g, input logic e, string s);
      chk({7'h00, g}, {7'h00, e}, s);
   endtask
   // Flag value expected from the route code, raw flags and polarity
   function automatic logic fexp(input int w, input logic [3:0] c,
                                 input logic [11:0] f, input logic [7:0] p);
      logic [1:0] k;
      logic [1:0] i;
      logic       v;
      k = c[3:2];
      i = c[1:0];
      if (c == 4'h0) begin
         k = (w == 1) ? 2'h3 : ((w == 2) ? 2'h2 : 2'h1);
         i = sel[1:0];
      end else if (c < 4'h4) begin
         return 1'b0;
      end
      v = f[{2'h3 - k, i}];
      if (k == 2'h2) return p[1] ? v : ~v;
      if (k == 2'h3) return p[0] ? v : ~v;
      return v;
   endfunction
   task automatic strobe(input int n, input logic tog, input int e);
      rdc = 0;
      wrc = 0;
      repeat (n) begin
         rd_s = 1'b0;
         wr_s = 1'b0;
         interface_clock_pin = tog ? ~interface_clock_pin : 1'b0;
         @(negedge clk);
      end
      rd_s = 1'b1;
      wr_s = 1'b1;
      interface_clock_pin = 1'b0;
      repeat (4) @(negedge clk);
      chk(8'(rdc), 8'(e), "read events");
      chk(8'(wrc), 8'(e), "write events");
   endtask
   task automatic pe_pulse(input logic act);
      pec = 0;
      pe_s = act;
      repeat (3) @(negedge clk);
      pe_s = ~act;
      repeat (3) @(negedge clk);
      chk(8'(pec), 8'h01, "packet end events");
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rchk(`REG_IF_CFG, 8'hC9);
      rchk(`REG_ROUTE_AB, 8'h00);
      rchk(`REG_ROUTE_CD, 8'h00);
      rchk(`REG_SENSE_CTL, 8'h00);
      bit_chk(pu, 1'b0, "pull-up idle");
      bit_chk(osc, 1'b0, "osc idle");
      chk({6'h00, cs, fd_oe}, 8'h02, "chip select mode");
      fd_pin = 1'b1;
      repeat (2) @(negedge clk);
      chk({6'h00, cs, fd_oe}, 8'h00, "chip deselected");
      fd_pin = 1'b0;
      wr(`REG_IF_CFG, 8'hC8);
      bit_chk(pu, 1'b1, "pull-up on");
      wr(`REG_IF_CFG, 8'hCB);
      chk({6'h00, cs, fd_oe}, 8'h01, "flag mode");
      bit_chk(pu, 1'b0, "pull-up off");
      wr(`REG_IF_CFG, 8'hC9);
      $display("test reset and config done");
   endtask
   task automatic t_signal_sense_ctl();
      logic ok;
      wr(`REG_SENSE_CTL, 8'hFF);
      rchk(`REG_SENSE_CTL, 8'hA3);
      oe_s = 1'b0;
      repeat (2) @(negedge clk);
      bit_chk(oe_a, 1'b1, "oe low");
      m_u.alt_rmw(8'h1C, ok);
      bit_chk(ok, 1'b1, "rmw read");
      rchk(`REG_SENSE_CTL, 8'hBF);
      rchk(`REG_IND_DATA, 8'hBF);
      repeat (2) @(negedge clk);
      bit_chk(oe_a, 1'b0, "oe low off");
      oe_s = 1'b1;
      repeat (2) @(negedge clk);
      bit_chk(oe_a, 1'b1, "oe high");
      m_u.ind_wr(16'hE608, 8'h00);
      rchk(`REG_SENSE_CTL, 8'hBF);
      rchk(`REG_IND_DATA, 8'h00);
      m_u.ind_wr(`ADDR_SENSE_ALT, 8'h00);
      wr(`REG_SENSE_CTL, 8'h00);
      rchk(`REG_SENSE_CTL, 8'h00);
      $display("test polarity done");
   endtask
   task automatic t_strobe();
      strobe(4, 1'b0, 1);
      wr(`REG_IF_CFG, 8'hC1);
      strobe(4, 1'b0, 4);
      wr(`REG_IF_CFG, 8'h41);
      strobe(4, 1'b0, 0);
      strobe(8, 1'b1, 4);
      wr(`REG_IF_CFG, 8'h51);
      strobe(8, 1'b1, 4);
      wr(`REG_IF_CFG, 8'hC9);
      pe_pulse(1'b0);
      pe_s = 1'b0;
      wr(`REG_SENSE_CTL, 8'h20);
      pe_pulse(1'b1);
      pe_s = 1'b1;
      wr(`REG_SENSE_CTL, 8'h00);
      $display("test strobes done");
   endtask
   task automatic t_standby();
      wr(`REG_IF_CFG, 8'hCD);
      bit_chk(osc, 1'b1, "standby");
      bus_act = 1'b1;
      @(negedge clk);
      bus_act = 1'b0;
      repeat (2) @(negedge clk);
      bit_chk(osc, 1'b0, "bus wake");
      wr(`REG_IF_CFG, 8'hCD);
      wake = 1'b0;
      @(negedge clk);
      wake = 1'b1;
      repeat (2) @(negedge clk);
      bit_chk(osc, 1'b0, "pin wake");
      wake = 1'b0;
      wr(`REG_SENSE_CTL, 8'h80);
      wr(`REG_IF_CFG, 8'hCD);
      repeat (3) @(negedge clk);
      bit_chk(osc, 1'b1, "low ignored");
      wake = 1'b1;
      @(negedge clk);
      wake = 1'b0;
      repeat (2) @(negedge clk);
      bit_chk(osc, 1'b0, "high wake");
      wr(`REG_SENSE_CTL, 8'h00);
      wake = 1'b1;
      wr(`REG_IF_CFG, 8'hC9);
      $display("test standby done");
   endtask
   task automatic t_flags();
      logic [7:0] pv;
      logic [3:0] c2;
      for (int p = 0; p < 2; p++) begin
         pv = (p == 1) ? 8'h03 : 8'h00;
         wr(`REG_SENSE_CTL, pv);
         for (int c = 0; c < 16; c++) begin
            c2 = 4'(15 - c);
            wr(`REG_ROUTE_AB, {c2, 4'(c)});
            wr(`REG_ROUTE_CD, {c2, 4'(c)});
            for (int j = 0; j < 12; j++) begin
               flags = 12'h001 << j;
               sel = 3'(j);
               repeat (2) @(negedge clk);
               bit_chk(fa, fexp(0, 4'(c), flags, pv), "flag A");
               bit_chk(fb, fexp(1, c2, flags, pv), "flag B");
               bit_chk(fc, fexp(2, 4'(c), flags, pv), "flag C");
               bit_chk(fd, fexp(3, c2, flags, pv), "flag D");
            end
         end
      end
      wr(`REG_ROUTE_AB, 8'h00);
      wr(`REG_ROUTE_CD, 8'h00);
      wr(`REG_SENSE_CTL, 8'h00);
      $display("test flag routing done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      arst_n = 1'b0;
      interface_clock_pin = 1'b0;
      rd_s = 1'b1;
      wr_s = 1'b1;
      oe_s = 1'b1;
      pe_s = 1'b1;
      wake = 1'b1;
      bus_act = 1'b0;
      fd_pin = 1'b0;
      sel = 3'h0;
      flags = '0;
      repeat (12) @(posedge clk);
      @(negedge clk);
      arst_n = 1'b1;
      t_reset();
      t_signal_sense_ctl();
      t_strobe();
      t_standby();
      t_flags();
      results();
   end
   // The full sequence needs about 1500 cycles
   initial begin
      repeat (6000) @(posedge clk);
      bad_count++;
      $display("ERROR t=%0t watchdog expired", $time);
      results();
   end
endmodule
`default_nettype wire
